// *** verilog/sph_switch_end.sv ***
`timescale 1ns/100ps
//What this block does
//- listening: only host frames, no learning
//- learning: learn sources, forward host frames only
//- forwarding: normal traffic and learning
//- discarding merges disable, blocking, listening
//- override entries still reach host port
//- learning disabled lets port entries flush
//- host sends nothing to discarding ports
//- three-bit spanning tree instance per frame
//- per-port state for each tree instance
//- host-bound frames carry ingress port tag
//- host tags frames with egress port
//- tag also carries priority queue
//- tags stripped before frame egresses
//- tagging enabled on one port only
//- tag sits before recomputed four-byte fcs
//- snooped group frames go only to host
//- group frame: ip version 4, protocol 2
//- host keeps override entries for control frames
module sph_switch_end
   import sph_pkg::*;
(
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   sys_rst,
   // link to host processor
   sph_link_if.sw                      lnk,
   // port state per port and tree instance, index port*NI+instance
   input  wire logic [NP*NI-1:0]       cfg_tx_en,
   input  wire logic [NP*NI-1:0]       cfg_rx_en,
   input  wire logic [NP*NI-1:0]       cfg_learn_dis,
   input  wire logic [NP-1:0]          cfg_tag_en,
   input  wire logic                   cfg_snoop_en,
   input  wire logic                   cfg_multi_q,
   // ingress frames from switch ports, without fcs
   input  wire logic                   in_valid,
   input  wire logic [7:0]             in_data,
   input  wire logic                   in_last,
   input  wire logic [PW-1:0]          in_port,
   input  wire logic [MW-1:0]          in_msti,
   input  wire logic [NP-1:0]          in_dest,
   input  wire logic                   in_override,
   input  wire logic [QW-1:0]          in_queue,
   output logic                        in_ready,
   // forwarding and learning decisions
   output logic                        fwd_valid,
   output logic [NP-1:0]               fwd_mask,
   output logic                        learn_valid,
   output logic [PW-1:0]               learn_port,
   output logic [NP*NI-1:0]            flush_ok,
   // host frames toward egress ports, tags and fcs removed
   output logic                        eg_valid,
   output logic [7:0]                  eg_data,
   output logic                        eg_last,
   output logic [NP-1:0]               eg_mask,
   output logic [QW-1:0]               eg_queue,
   input  wire logic                   eg_ready
);
   import sph_pkg::*;

   sph_dn_t       dn_st_reg;
   logic [31:0]   crc_reg;
   logic [1:0]    fcs_idx_reg;
   logic [7:0]    tag0_reg;
   logic [7:0]    tag1_reg;
   logic          keep_reg;
   logic [10:0]   bc_reg;
   logic [7:0]    type_hi_reg;
   logic          eth_ip_reg;
   logic          snap_ok_reg;
   logic          ver_ok_reg;
   logic          igmp_reg;
   logic [PW-1:0] host_idx_reg;
   logic          host_vld_reg;
   logic [7:0]    line_reg [6];
   logic [2:0]    cnt_reg;
   logic          h2s_ready_reg;
   logic          s2h_valid_reg;
   logic [7:0]    s2h_data_reg;
   logic          s2h_last_reg;
   logic          s2h_drop_reg;

   logic          take;
   logic          out_free;
   logic          up_take;
   logic          eg_free;
   logic          host_ok;
   logic [NP-1:0] user_mask;
   logic          src_rx;
   logic          trap;
   int            si;

   assign take     = in_ready && in_valid;
   assign out_free = !s2h_valid_reg || lnk.s2h_ready;
   assign up_take  = h2s_ready_reg && lnk.h2s_valid;
   assign eg_free  = !eg_valid || eg_ready;

   assign lnk.s2h_valid = s2h_valid_reg;
   assign lnk.s2h_data  = s2h_data_reg;
   assign lnk.s2h_last  = s2h_last_reg;
   assign lnk.s2h_drop  = s2h_drop_reg;
   assign lnk.h2s_ready = h2s_ready_reg;

   // host port is the lowest port with tagging on
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         host_idx_reg <= '0;
         host_vld_reg <= 1'b0;
      end else begin
         host_idx_reg <= '0;
         host_vld_reg <= 1'b0;
         for (int p = NP - 1; p >= 0; p--) begin
            if (cfg_tag_en[p]) begin
               host_idx_reg <= PW'(p);
               host_vld_reg <= 1'b1;
            end
         end
      end
   end

   // group-membership frame recognition
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         bc_reg      <= '0;
         type_hi_reg <= '0;
         eth_ip_reg  <= 1'b0;
         snap_ok_reg <= 1'b0;
         ver_ok_reg  <= 1'b0;
         igmp_reg    <= 1'b0;
      end else if (take) begin
         if (in_last) begin
            bc_reg      <= '0;
            eth_ip_reg  <= 1'b0;
            snap_ok_reg <= 1'b0;
            ver_ok_reg  <= 1'b0;
            igmp_reg    <= 1'b0;
         end else begin
            if (bc_reg != BC_MAX)
               bc_reg <= bc_reg + 11'd1;
            if (bc_reg == BO_TYPE_HI)
               type_hi_reg <= in_data;
            if (bc_reg == BO_TYPE_LO) begin
               eth_ip_reg  <= {type_hi_reg, in_data} == ETH_IPV4;
               snap_ok_reg <= {type_hi_reg, in_data} < ETH_LEN_MAX;
            end
            if (bc_reg >= BO_SNAP && bc_reg <= BO_SNAP_END) begin
               if (in_data != (bc_reg < BO_SNAP_UI ? SNAP_AA :
                               bc_reg == BO_SNAP_UI ? SNAP_UI : SNAP_ZERO))
                  snap_ok_reg <= 1'b0;
            end
            if ((bc_reg == BO_SNAP_THI && in_data != TYPE_HI) ||
                (bc_reg == BO_SNAP_TLO && in_data != SNAP_ZERO))
               snap_ok_reg <= 1'b0;
            if ((eth_ip_reg && bc_reg == BO_IP_ETH) ||
                (snap_ok_reg && bc_reg == BO_IP_SNAP))
               ver_ok_reg <= in_data[7:4] == IP_VER4;
            if ((eth_ip_reg && bc_reg == BO_IP_ETH + IP_PROTO_OFS) ||
                (snap_ok_reg && bc_reg == BO_IP_SNAP + IP_PROTO_OFS))
               igmp_reg <= ver_ok_reg && in_data == IP_PROTO_IGMP;
         end
      end
   end

   // per frame decision from the source port's state in its instance
   always_comb begin
      si        = int'(in_port) * NI + int'(in_msti);
      src_rx    = cfg_rx_en[si];
      trap      = cfg_snoop_en && igmp_reg;
      host_ok   = host_vld_reg && in_port != host_idx_reg &&
                  (in_dest[host_idx_reg] || trap) &&
                  (src_rx || in_override);
      user_mask = '0;
      for (int p = 0; p < NP; p++) begin
         user_mask[p] = in_dest[p] && src_rx && !trap &&
                        cfg_tx_en[p*NI + int'(in_msti)] &&
                        !(host_vld_reg && PW'(p) == host_idx_reg);
      end
   end

   // fwd and learn outputs pulsed the cycle after the last ingress byte, flush_ok follows cfg_learn_dis
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         fwd_valid   <= 1'b0;
         fwd_mask    <= '0;
         learn_valid <= 1'b0;
         learn_port  <= '0;
         flush_ok    <= '0;
      end else begin
         flush_ok    <= cfg_learn_dis;
         fwd_valid   <= take && in_last;
         learn_valid <= take && in_last && !cfg_learn_dis[si];
         if (take && in_last) begin
            fwd_mask   <= user_mask;
            learn_port <= in_port;
         end
      end
   end

   // toward host: frame bytes, two tag bytes, fresh fcs
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         dn_st_reg     <= DN_DATA;
         crc_reg       <= CRC_INIT;
         fcs_idx_reg   <= '0;
         tag0_reg      <= '0;
         tag1_reg      <= '0;
         keep_reg      <= 1'b0;
         in_ready      <= 1'b0;
         s2h_valid_reg <= 1'b0;
         s2h_data_reg  <= '0;
         s2h_last_reg  <= 1'b0;
         s2h_drop_reg  <= 1'b0;
      end else begin
         if (s2h_valid_reg && lnk.s2h_ready)
            s2h_valid_reg <= 1'b0;
         in_ready <= in_ready ? !in_valid :
                     (out_free && dn_st_reg == DN_DATA && !take);
         unique case (dn_st_reg)
            DN_DATA: if (take) begin
               s2h_valid_reg <= 1'b1;
               s2h_data_reg  <= in_data;
               s2h_last_reg  <= 1'b0;
               s2h_drop_reg  <= 1'b0;
               crc_reg       <= sph_crc(crc_reg, in_data);
               if (in_last) begin
                  dn_st_reg <= DN_TAG0;
                  keep_reg  <= host_ok;
                  tag0_reg  <= '0;
                  if (cfg_multi_q)
                     tag0_reg[TAG_Q_LSB +: QW] <= in_queue;
                  tag1_reg <= '0;
                  tag1_reg[in_port] <= 1'b1;
               end
            end
            DN_TAG0: if (out_free) begin
               s2h_valid_reg <= 1'b1;
               s2h_data_reg  <= tag0_reg;
               crc_reg       <= sph_crc(crc_reg, tag0_reg);
               dn_st_reg     <= DN_TAG1;
            end
            DN_TAG1: if (out_free) begin
               s2h_valid_reg <= 1'b1;
               s2h_data_reg  <= tag1_reg;
               crc_reg       <= sph_crc(crc_reg, tag1_reg);
               fcs_idx_reg   <= '0;
               dn_st_reg     <= DN_FCS;
            end
            DN_FCS: if (out_free) begin
               s2h_valid_reg <= 1'b1;
               s2h_data_reg  <= sph_fcs(crc_reg, fcs_idx_reg);
               fcs_idx_reg   <= fcs_idx_reg + 2'd1;
               if (fcs_idx_reg == FCS_LAST) begin
                  s2h_last_reg <= 1'b1;
                  s2h_drop_reg <= !keep_reg;
                  crc_reg      <= CRC_INIT;
                  dn_st_reg    <= DN_DATA;
               end
            end
         endcase
      end
   end

   // from host: hold back six bytes, strip tags and fcs
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < 6; i++)
            line_reg[i] <= '0;
         cnt_reg       <= '0;
         h2s_ready_reg <= 1'b0;
         eg_valid      <= 1'b0;
         eg_data       <= '0;
         eg_last       <= 1'b0;
         eg_mask       <= '0;
         eg_queue      <= '0;
      end else begin
         if (eg_valid && eg_ready)
            eg_valid <= 1'b0;
         h2s_ready_reg <= h2s_ready_reg ? !lnk.h2s_valid :
                          (eg_free && !up_take);
         if (up_take) begin
            line_reg[0] <= lnk.h2s_data;
            for (int i = 1; i < 6; i++)
               line_reg[i] <= line_reg[i-1];
            if (cnt_reg == TRAIL_LEN) begin
               eg_valid <= 1'b1;
               eg_data  <= line_reg[5];
               eg_last  <= lnk.h2s_last;
               if (lnk.h2s_last) begin
                  eg_mask <= line_reg[3][NP-1:0];
                  eg_queue <= cfg_multi_q ?
                     line_reg[4][TAG_Q_LSB +: QW] : '0;
                  if (host_vld_reg)
                     eg_mask[host_idx_reg] <= 1'b0;
               end
            end
            if (lnk.h2s_last)
               cnt_reg <= '0;
            else if (cnt_reg != TRAIL_LEN)
               cnt_reg <= cnt_reg + 3'd1;
         end
      end
   end

endmodule

// *** verilog/sph_pkg.sv ***
package sph_pkg;

   // switch geometry
   localparam int NP = 7;
   localparam int NI = 8;
   localparam int PW = 3;
   localparam int MW = 3;
   localparam int QW = 2;

   // frame check sequence
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;

   // frame parsing
   localparam logic [15:0] ETH_IPV4      = 16'h0800;
   localparam logic [15:0] ETH_LEN_MAX   = 16'h0600;
   localparam logic [7:0]  SNAP_AA       = 8'haa;
   localparam logic [7:0]  SNAP_UI       = 8'h03;
   localparam logic [7:0]  SNAP_ZERO     = 8'h00;
   localparam logic [7:0]  TYPE_HI       = 8'h08;
   localparam logic [3:0]  IP_VER4       = 4'h4;
   localparam logic [7:0]  IP_PROTO_IGMP = 8'h02;
   localparam logic [10:0] BO_TYPE_HI    = 11'd12;
   localparam logic [10:0] BO_TYPE_LO    = 11'd13;
   localparam logic [10:0] BO_SNAP       = 11'd14;
   localparam logic [10:0] BO_SNAP_UI    = 11'd16;
   localparam logic [10:0] BO_SNAP_END   = 11'd19;
   localparam logic [10:0] BO_SNAP_THI   = 11'd20;
   localparam logic [10:0] BO_SNAP_TLO   = 11'd21;
   localparam logic [10:0] BO_IP_ETH     = 11'd14;
   localparam logic [10:0] BO_IP_SNAP    = 11'd22;
   localparam logic [10:0] IP_PROTO_OFS  = 11'd9;
   localparam logic [10:0] BC_MAX        = 11'h7ff;

   // tail: two tag bytes then four fcs bytes
   localparam logic [2:0] TRAIL_LEN = 3'd6;
   localparam logic [1:0] FCS_LAST  = 2'd3;
   localparam int         TAG_Q_LSB = 0;

   // host controller registers
   localparam logic [7:0] A_TXTAG  = 8'h00;
   localparam logic [7:0] A_TXDATA = 8'h04;
   localparam logic [7:0] A_RXDATA = 8'h08;
   localparam logic [7:0] A_RXTAG  = 8'h0c;
   localparam logic [7:0] A_DISC   = 8'h10;
   localparam int TXQ_LSB    = 8;
   localparam int TX_LAST_B  = 8;
   localparam int RX_LAST_B  = 8;
   localparam int RX_DROP_B  = 9;
   localparam int RX_VALID_B = 31;
   localparam logic [NP-1:0] DISC_RST  = 7'h00;
   localparam logic [NP-1:0] TXDST_RST = 7'h00;
   localparam logic [QW-1:0] TXQ_RST   = 2'h0;

   // host transmit phases
   localparam logic [2:0] TX_IDLE = 3'd0;
   localparam logic [2:0] TX_TAG0 = 3'd1;
   localparam logic [2:0] TX_TAG1 = 3'd2;
   localparam logic [2:0] TX_FCS0 = 3'd3;
   localparam logic [2:0] TX_FCS3 = 3'd6;

   typedef enum logic [1:0] {DN_DATA, DN_TAG0, DN_TAG1, DN_FCS} sph_dn_t;

   function automatic logic [31:0] sph_crc(input logic [31:0] c,
                                            input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // fcs bytes go out least significant first
   function automatic logic [7:0] sph_fcs(input logic [31:0] c,
                                           input logic [1:0] i);
      logic [31:0] n;
      n = ~c;
      return n[8*i +: 8];
   endfunction

endpackage

// *** verilog/sph_link_if.sv ***
`timescale 1ns/100ps
interface sph_link_if;
   logic       s2h_valid;
   logic [7:0] s2h_data;
   logic       s2h_last;
   logic       s2h_drop;
   logic       s2h_ready;
   logic       h2s_valid;
   logic [7:0] h2s_data;
   logic       h2s_last;
   logic       h2s_ready;

   modport sw (output s2h_valid, s2h_data, s2h_last, s2h_drop, h2s_ready,
               input s2h_ready, h2s_valid, h2s_data, h2s_last);
   modport host (input s2h_valid, s2h_data, s2h_last, s2h_drop, h2s_ready,
                 output s2h_ready, h2s_valid, h2s_data, h2s_last);
endinterface

// *** verilog/sph_host_end.sv ***
`timescale 1ns/100ps
module sph_host_end
   import sph_pkg::*;
(
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   // apb slave
   input  wire logic [7:0]   paddr,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // link to switch
   sph_link_if.host          lnk
);
   import sph_pkg::*;

   logic [NP-1:0] disc_reg;
   logic [NP-1:0] tx_dst_reg;
   logic [QW-1:0] tx_q_reg;
   logic [2:0]    tx_ph_reg;
   logic [31:0]   crc_reg;
   logic          h2s_valid_reg;
   logic [7:0]    h2s_data_reg;
   logic          h2s_last_reg;
   logic          s2h_ready_reg;
   logic [7:0]    rx_byte_reg;
   logic          rx_full_reg;
   logic          rx_last_reg;
   logic          rx_drop_reg;
   logic [7:0]    hist_reg [5];
   logic [NP-1:0] rx_src_reg;
   logic [QW-1:0] rx_q_reg;

   logic          access;
   logic          done;
   logic          tx_free;
   logic          tx_wr;
   logic          rx_take;
   logic [7:0]    tag0;
   logic [7:0]    tag1;

   assign access  = psel && penable && !pready;
   assign done    = psel && penable && pready;
   assign tx_free = !h2s_valid_reg || lnk.h2s_ready;
   assign tx_wr   = done && pwrite && paddr == A_TXDATA;
   assign rx_take = s2h_ready_reg && lnk.s2h_valid;

   assign lnk.h2s_valid = h2s_valid_reg;
   assign lnk.h2s_data  = h2s_data_reg;
   assign lnk.h2s_last  = h2s_last_reg;
   assign lnk.s2h_ready = s2h_ready_reg;

   always_comb begin
      tag0 = '0;
      tag0[TAG_Q_LSB +: QW] = tx_q_reg;
      tag1 = {1'b0, tx_dst_reg & ~disc_reg};
   end

   // apb register access
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= '0;
         disc_reg   <= DISC_RST;
         tx_dst_reg <= TXDST_RST;
         tx_q_reg   <= TXQ_RST;
      end else begin
         pready <= 1'b0;
         if (access) begin
            pslverr <= 1'b0;
            prdata  <= '0;
            unique case (paddr)
               A_TXTAG: begin
                  pready <= 1'b1;
                  prdata <= {22'h0, tx_q_reg, 1'b0, tx_dst_reg};
               end
               A_TXDATA: pready <= tx_ph_reg == TX_IDLE && !h2s_valid_reg;
               A_RXDATA: begin
                  pready <= 1'b1;
                  prdata <= {rx_full_reg, 21'h0, rx_drop_reg,
                             rx_last_reg, rx_byte_reg};
               end
               A_RXTAG: begin
                  pready <= 1'b1;
                  prdata <= {22'h0, rx_q_reg, 1'b0, rx_src_reg};
               end
               A_DISC: begin
                  pready <= 1'b1;
                  prdata <= {25'h0, disc_reg};
               end
               default: begin
                  pready  <= 1'b1;
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (done && pwrite && paddr == A_TXTAG) begin
            tx_dst_reg <= pwdata[NP-1:0];
            tx_q_reg   <= pwdata[TXQ_LSB +: QW];
         end
         if (done && pwrite && paddr == A_DISC)
            disc_reg <= pwdata[NP-1:0];
      end
   end

   // transmit: payload from software, then tag bytes and fcs
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tx_ph_reg     <= TX_IDLE;
         crc_reg       <= CRC_INIT;
         h2s_valid_reg <= 1'b0;
         h2s_data_reg  <= '0;
         h2s_last_reg  <= 1'b0;
      end else begin
         if (h2s_valid_reg && lnk.h2s_ready)
            h2s_valid_reg <= 1'b0;
         if (tx_wr) begin
            h2s_valid_reg <= 1'b1;
            h2s_data_reg  <= pwdata[7:0];
            h2s_last_reg  <= 1'b0;
            crc_reg       <= sph_crc(crc_reg, pwdata[7:0]);
            if (pwdata[TX_LAST_B])
               tx_ph_reg <= TX_TAG0;
         end else if (tx_ph_reg != TX_IDLE && tx_free) begin
            h2s_valid_reg <= 1'b1;
            tx_ph_reg     <= tx_ph_reg + 3'd1;
            if (tx_ph_reg == TX_TAG0) begin
               h2s_data_reg <= tag0;
               crc_reg      <= sph_crc(crc_reg, tag0);
            end else if (tx_ph_reg == TX_TAG1) begin
               h2s_data_reg <= tag1;
               crc_reg      <= sph_crc(crc_reg, tag1);
            end else begin
               h2s_data_reg <= sph_fcs(crc_reg, 2'(tx_ph_reg - TX_FCS0));
               if (tx_ph_reg == TX_FCS3) begin
                  h2s_last_reg <= 1'b1;
                  crc_reg      <= CRC_INIT;
                  tx_ph_reg    <= TX_IDLE;
               end
            end
         end
      end
   end

   // receive: one byte held for software, tag caught at frame end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s2h_ready_reg <= 1'b0;
         rx_full_reg   <= 1'b0;
         rx_byte_reg   <= '0;
         rx_last_reg   <= 1'b0;
         rx_drop_reg   <= 1'b0;
         rx_src_reg    <= '0;
         rx_q_reg      <= '0;
         for (int i = 0; i < 5; i++)
            hist_reg[i] <= '0;
      end else begin
         s2h_ready_reg <= !rx_full_reg && !rx_take;
         if (done && !pwrite && paddr == A_RXDATA && prdata[RX_VALID_B])
            rx_full_reg <= 1'b0;
         if (rx_take) begin
            rx_full_reg <= 1'b1;
            rx_byte_reg <= lnk.s2h_data;
            rx_last_reg <= lnk.s2h_last;
            rx_drop_reg <= 1'b0;
            hist_reg[0] <= lnk.s2h_data;
            for (int i = 1; i < 5; i++)
               hist_reg[i] <= hist_reg[i-1];
            if (lnk.s2h_last) begin
               rx_src_reg  <= hist_reg[3][NP-1:0];
               rx_q_reg    <= hist_reg[4][TAG_Q_LSB +: QW];
               rx_drop_reg <= lnk.s2h_drop ||
                              |(hist_reg[3][NP-1:0] & disc_reg);
            end
         end
      end
   end

endmodule

// *** tb/sph_link_properties.sv ***
`timescale 1ns/100ps
module sph_link_properties (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   // link signals
   input wire logic       s2h_valid,
   input wire logic [7:0] s2h_data,
   input wire logic       s2h_last,
   input wire logic       s2h_drop,
   input wire logic       s2h_ready,
   input wire logic       h2s_valid,
   input wire logic [7:0] h2s_data,
   input wire logic       h2s_last,
   input wire logic       h2s_ready
);
   logic [7:0] hist_reg [5];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_end; s2h_valid && s2h_ready && s2h_last; endsequence
   sequence h_take; h2s_valid && h2s_ready; endsequence
   sequence h_end; h2s_valid && h2s_ready && h2s_last; endsequence
   // last five bytes taken by the host
   always_ff @(posedge clk_sys) begin
      if (s2h_valid && s2h_ready) begin
         hist_reg[0] <= s2h_data;
         for (int i = 1; i < 5; i++) begin
            hist_reg[i] <= hist_reg[i-1];
         end
      end
   end
   a_s2h_hold: assert property (s2h_valid && !s2h_ready |=> s2h_valid
      && $stable(s2h_data)) else $error("down byte not held");
   a_h2s_hold: assert property (h2s_valid && !h2s_ready |=> h2s_valid
      && $stable(h2s_data) && $stable(h2s_last)) else $error("up byte lost");
   a_h2s_gap: assert property (h_take |=> !h2s_ready)
      else $error("up ready not dropped");
   a_drop_last: assert property (s2h_valid && s2h_drop |-> s2h_last)
      else $error("drop off last byte");
   a_tag_port: assert property (s_end |-> hist_reg[3][7] == 1'b0
      && $onehot(hist_reg[3][6:0])) else $error("port tag not one-hot");
   a_tag_queue: assert property (s_end |-> hist_reg[4][7:2] == 6'h00)
      else $error("queue tag bad");
   a_down_frame: assert property (s_end |=> !(s2h_valid && s2h_last))
      else $error("down trailer short");
   a_up_frame: assert property (h_end |=> !(h2s_valid && h2s_last))
      else $error("up trailer short");
endmodule

// *** tb/tb_switch_port_state_host_tagging.sv ***
`timescale 1ns/100ps
module tb_switch_port_state_host_tagging;
   import sph_pkg::*;
   localparam logic [2:0] R_ST [5] = '{3'b110, 3'b000, 3'b001, 3'b110, 3'b110};
   localparam logic [2:0] R_MI [5] = '{3'd0, 3'd0, 3'd0, 3'd3, 3'd3};
   // override, disc, igmp, learn, drop
   localparam logic [4:0] R_FL [5] = '{5'h02, 5'h12, 5'h19, 5'h02, 5'h06};
   localparam logic [6:0] R_FW [5] = '{7'h04, 7'h00, 7'h00, 7'h04, 7'h00};
   logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, in_valid = 1'b0, in_last = 1'b0, in_override = 1'b0;
   logic cfg_snoop_en = 1'b0, got_l = 1'b0, e;
   logic [NP*NI-1:0] cfg_tx_en = '1, cfg_rx_en = '1, cfg_learn_dis = '0;
   logic [7:0] paddr = 8'h00, in_data = 8'h00, eg_n = 8'h00, eg_b [16];
   logic [31:0] pwdata = 32'h0, r;
   logic [MW-1:0] in_msti = '0;
   logic [NP-1:0] in_dest = 7'h44, got_f = '0, em;
   logic [QW-1:0] eq;
   int n_errors = 0, n_tests = 0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, in_ready, fwd_valid, learn_valid;
   wire logic eg_valid, eg_last;
   wire logic [7:0] eg_data;
   wire logic [NP-1:0] fwd_mask, eg_mask;
   wire logic [PW-1:0] learn_port;
   wire logic [QW-1:0] eg_queue;
   wire logic [NP*NI-1:0] flush_ok;
   sph_link_if u_sph_link_if ();
   sph_switch_end u_sph_switch_end (.clk_sys, .sys_rst, .lnk(u_sph_link_if),
      .cfg_tx_en, .cfg_rx_en, .cfg_learn_dis, .cfg_snoop_en,
      .cfg_tag_en(7'h40),
      .cfg_multi_q(1'b1), .in_valid, .in_data, .in_last, .in_port(3'd1),
      .in_msti, .in_dest, .in_override, .in_queue(2'd2), .in_ready, .fwd_valid,
      .fwd_mask, .learn_valid, .learn_port, .flush_ok, .eg_valid, .eg_data,
      .eg_last, .eg_mask, .eg_queue, .eg_ready(1'b1));
   sph_host_end u_sph_host_end (.clk_sys, .sys_rst, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .lnk(u_sph_link_if));
   sph_link_properties u_props (.clk_sys, .sys_rst,
      .s2h_valid(u_sph_link_if.s2h_valid), .s2h_data(u_sph_link_if.s2h_data),
      .s2h_last(u_sph_link_if.s2h_last), .s2h_drop(u_sph_link_if.s2h_drop),
      .s2h_ready(u_sph_link_if.s2h_ready), .h2s_valid(u_sph_link_if.h2s_valid),
      .h2s_data(u_sph_link_if.h2s_data), .h2s_last(u_sph_link_if.h2s_last),
      .h2s_ready(u_sph_link_if.h2s_ready));
   initial forever #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (learn_valid) got_l <= learn_port == 3'd1;
      if (fwd_valid) got_f <= fwd_mask;
      if (eg_valid) begin
         eg_b[eg_n[3:0]] <= eg_data;
         eg_n <= eg_n + 8'd1;
         if (eg_last) begin
            em <= eg_mask;
            eq <= eg_queue;
         end
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task frame(input int k);
      logic [7:0] i, b, n;
      apb(1'b1, A_DISC, R_FL[k][3] ? 32'h02 : 32'h00);
      {cfg_tx_en[8+R_MI[k]], cfg_rx_en[8+R_MI[k]]} <= R_ST[k][2:1];
      cfg_learn_dis[8+R_MI[k]] <= R_ST[k][0];
      {in_msti, in_override, cfg_snoop_en} <= {R_MI[k], R_FL[k][4], R_FL[k][2]};
      @(posedge clk_sys);
      {got_l, got_f} <= '0;
      n = 8'd0;
      // host drains bytes while the frame is fed
      fork
         begin
            for (i = 0; i < 28; i++) begin
               b = 8'h10 + i;
               if (R_FL[k][2]) begin
                  case (i)
                     8'd12: b = 8'h08;
                     8'd13: b = 8'h00;
                     8'd14: b = 8'h45;
                     8'd23: b = 8'h02;
                     default: ;
                  endcase
               end
               {in_valid, in_data, in_last} <= {1'b1, b, i == 8'd27};
               do @(posedge clk_sys); while (in_ready !== 1'b1);
            end
            {in_valid, in_last} <= 2'b00;
         end
         do begin
            apb(1'b0, A_RXDATA, 32'h0);
            if (r[31] && n == 8'd0) chk(32'(r[7:0]), 32'h10);
            if (r[31]) n++;
         end while (!(r[31] && r[8]));
      join
      chk(32'(got_l), 32'(R_FL[k][1]));
      chk(32'(got_f), 32'(R_FW[k]));
      chk(32'(r[9]), 32'(R_FL[k][0]));
      apb(1'b0, A_RXTAG, 32'h0);
      chk(32'(r[9:0]), 32'h202);
   endtask
   task finish_test;
      if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_errors++;
      finish_test;
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      for (int k = 0; k < 5; k++) frame(k);
      apb(1'b1, A_TXTAG, 32'h104);
      for (logic [7:0] i = 0; i < 8; i++) begin
         apb(1'b1, A_TXDATA, {23'h0, i == 8'd7, 8'ha0 + i});
      end
      for (int j = 0; j < 300 && eg_n < 8; j++) @(posedge clk_sys);
      chk(32'(eg_n), 32'd8);
      chk(32'(eg_b[7]), 32'ha7);
      chk(32'(em), 32'h04);
      chk(32'(eq), 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk({r[30:0], e}, 32'h1);
      chk(32'(flush_ok === cfg_learn_dis), 32'h1);
      finish_test;
   end
endmodule
